/* File: include/lnctl_defs.svh */
/*
 * offsets, field positions, reset values and timing counts of the
 * two-wire line control block.
 * assumes a 32-bit apb register bus with one register per aligned word.
 */
`ifndef LNCTL_DEFS_SVH
`define LNCTL_DEFS_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define LNCTL_OFS_LINE 12'h000
`define LNCTL_OFS_MODE 12'h004
`define LNCTL_OFS_XCTL 12'h008
`define LNCTL_OFS_DATA 12'h00c

// ----------------------------------------------------------------
// line_level_control fields
// ----------------------------------------------------------------
`define LNCTL_LINE_SDA_BIT 5
`define LNCTL_LINE_SDA_WP_BIT 4
`define LNCTL_LINE_RST_BIT 1
`define LNCTL_LINE_SDA_RST 1'b1
`define LNCTL_LINE_RST_RST 1'b0

// ----------------------------------------------------------------
// bus_mode_select fields
// ----------------------------------------------------------------
`define LNCTL_MODE_ORDER_BIT 7
`define LNCTL_MODE_WAIT_BIT 6
`define LNCTL_MODE_BC_WP_BIT 3
`define LNCTL_MODE_BC_MSB 2
`define LNCTL_MODE_RESV 2'h3

// ----------------------------------------------------------------
// transfer_control fields
// ----------------------------------------------------------------
`define LNCTL_XCTL_GO_BIT 0
`define LNCTL_XCTL_MASTER_BIT 1
`define LNCTL_XCTL_I2C_BIT 2
`define LNCTL_XCTL_BUSY_BIT 7

// ----------------------------------------------------------------
// transfer lengths and wait
// ----------------------------------------------------------------
`define LNCTL_BITS_I2C_FULL 4'h9
`define LNCTL_BITS_SYNC_FULL 4'h8
`define LNCTL_WAIT_XFER_CLKS 2
`define LNCTL_LINK_PER_XFER 2

`endif

/* File: include/lnctl_pkg.sv */
/*
 * types of the two-wire line control block.
 * assumes lnctl_defs.svh for all numeric constants except the state encodings, which are set here.
 */
package lnctl_pkg;

   typedef enum logic [1:0] {
      LNCTL_ST_IDLE = 2'b00,
      LNCTL_ST_LOW = 2'b01,
      LNCTL_ST_HIGH = 2'b10,
      LNCTL_ST_WAIT = 2'b11
   } lnctl_state_t;

   typedef struct packed {
      logic lsb_first;
      logic wait_en;
      logic master;
      logic i2c_fmt;
   } lnctl_mode_t;

endpackage : lnctl_pkg

/* File: rtl/lnctl_top.sv */
/*
 * two-wire line control block: apb register side on pclk, serial
 * engine on link_clk (one link_clk period per scl half period).
 * assumes external pull-ups on scl and sda and an apb3 master.
 */
`timescale 1ns/1ps
`include "lnctl_defs.svh"

module lnctl_top
   import lnctl_pkg::*;
#(
   parameter int WAIT_LINK_CYC = `LNCTL_WAIT_XFER_CLKS * `LNCTL_LINK_PER_XFER
) (
   // system
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // link
   input wire logic link_clk,
   input wire logic scl_i,
   output logic scl_o,
   output logic scl_oe,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe
);

   // ----------------------------------------------------------------
   // gray helpers
   // ----------------------------------------------------------------
   function automatic logic [2:0] bin2gray(input logic [2:0] b);
      bin2gray = b ^ (b >> 1);
   endfunction : bin2gray

   function automatic logic [2:0] gray2bin(input logic [2:0] g);
      gray2bin = {g[2], g[2] ^ g[1], g[2] ^ g[1] ^ g[0]};
   endfunction : gray2bin

   // ----------------------------------------------------------------
   // declarations, pclk domain first, then link domain
   // ----------------------------------------------------------------
   logic sda_lvl_reg;
   logic srst_reg;
   lnctl_mode_t mode_reg;
   logic [7:0] tx_reg;
   logic [7:0] rx_pc_reg;
   logic start_tgl_reg;
   logic [2:0] bcld_val_reg;
   logic bcld_tgl_reg;
   logic [2:0] done_p_reg;
   logic [1:0] scl_p_reg;
   logic [1:0] busy_p_reg;
   logic [2:0] bcg_p1_reg;
   logic [2:0] bcg_p2_reg;
   logic pready_reg;
   logic pslverr_reg;
   logic [31:0] prdata_reg;
   logic [1:0] ce_l_reg;
   logic [1:0] srst_l_reg;
   logic [1:0] sda_lvl_l_reg;
   lnctl_mode_t mode_l1_reg;
   lnctl_mode_t mode_l2_reg;
   logic [2:0] start_l_reg;
   logic [2:0] bcld_l_reg;
   logic [1:0] sda_in_reg;
   logic [1:0] scl_in_reg;
   lnctl_state_t state_reg;
   logic [3:0] rem_reg;
   logic [2:0] bc_reg;
   logic [2:0] bcg_reg;
   logic [7:0] sh_reg;
   logic [7:0] rx_reg;
   logic [7:0] wcnt_reg;
   logic done_tgl_reg;
   logic busy_reg;
   logic scl_oe_reg;
   logic sda_oe_reg;

   // ----------------------------------------------------------------
   // apb decode and answer: one wait state, unmapped gives pslverr
   // ----------------------------------------------------------------
   wire logic acc = psel & penable & ~pready_reg & ce;
   wire logic wr = psel & penable & pready_reg & pwrite & ce;
   wire logic hit_line = paddr == `LNCTL_OFS_LINE;
   wire logic hit_mode = paddr == `LNCTL_OFS_MODE;
   wire logic hit_xctl = paddr == `LNCTL_OFS_XCTL;
   wire logic hit_data = paddr == `LNCTL_OFS_DATA;
   wire logic hit_any = hit_line | hit_mode | hit_xctl | hit_data;
   wire logic wr_line = wr & hit_line;
   wire logic wr_mode = wr & hit_mode;
   wire logic wr_xctl = wr & hit_xctl;
   wire logic wr_data = wr & hit_data;
   wire logic sda_upd = wr_line & ~pwdata[`LNCTL_LINE_SDA_WP_BIT];
   wire logic bc_upd = wr_mode & ~pwdata[`LNCTL_MODE_BC_WP_BIT];
   wire logic go = wr_xctl & pwdata[`LNCTL_XCTL_GO_BIT] & ~busy_p_reg[1];
   wire logic done_evt = done_p_reg[2] ^ done_p_reg[1];
   wire logic [2:0] bc_rd = gray2bin(bcg_p2_reg);
   wire logic [7:0] line_rd = {1'b0, 1'b1, sda_lvl_reg, 1'b1,
                               scl_p_reg[1], 1'b1, srst_reg, 1'b1};
   wire logic [7:0] mode_rd = {mode_reg.lsb_first, mode_reg.wait_en,
                               `LNCTL_MODE_RESV, 1'b1, bc_rd};
   wire logic [7:0] xctl_rd = {busy_p_reg[1], 4'h0, mode_reg.i2c_fmt,
                               mode_reg.master, 1'b0};
   wire logic [7:0] rd_mux = hit_line ? line_rd :
                             hit_mode ? mode_rd :
                             hit_xctl ? xctl_rd :
                             hit_data ? rx_pc_reg : 8'h00;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_reg <= 1'b0;
         pslverr_reg <= 1'b0;
         prdata_reg <= 32'h0000_0000;
      end else if (ce) begin
         pready_reg <= acc;
         pslverr_reg <= acc & ~hit_any;
         prdata_reg <= (acc & ~pwrite) ? {24'h00_0000, rd_mux} : 32'h0000_0000;
      end
   end

   // ----------------------------------------------------------------
   // software registers
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sda_lvl_reg <= `LNCTL_LINE_SDA_RST;
         srst_reg <= `LNCTL_LINE_RST_RST;
         mode_reg <= '0;
      end else if (ce) begin
         if (sda_upd)
            sda_lvl_reg <= pwdata[`LNCTL_LINE_SDA_BIT];
         if (wr_line)
            srst_reg <= pwdata[`LNCTL_LINE_RST_BIT];
         if (wr_mode) begin
            mode_reg.lsb_first <= pwdata[`LNCTL_MODE_ORDER_BIT];
            mode_reg.wait_en <= pwdata[`LNCTL_MODE_WAIT_BIT];
         end
         if (wr_xctl) begin
            mode_reg.master <= pwdata[`LNCTL_XCTL_MASTER_BIT];
            mode_reg.i2c_fmt <= pwdata[`LNCTL_XCTL_I2C_BIT];
         end
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_reg <= 8'h00;
         start_tgl_reg <= 1'b0;
         bcld_val_reg <= 3'h0;
         bcld_tgl_reg <= 1'b0;
         rx_pc_reg <= 8'h00;
      end else if (ce) begin
         if (wr_data)
            tx_reg <= pwdata[7:0];
         if (go)
            start_tgl_reg <= ~start_tgl_reg;
         if (bc_upd) begin
            bcld_val_reg <= pwdata[`LNCTL_MODE_BC_MSB:0];
            bcld_tgl_reg <= ~bcld_tgl_reg;
         end
         if (done_evt)
            rx_pc_reg <= rx_reg;
      end
   end

   // ----------------------------------------------------------------
   // clock domain synchronisers
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         done_p_reg <= 3'h0;
         scl_p_reg <= 2'h3;
         busy_p_reg <= 2'h0;
         bcg_p1_reg <= 3'h0;
         bcg_p2_reg <= 3'h0;
      end else if (ce) begin
         done_p_reg <= {done_p_reg[1:0], done_tgl_reg};
         scl_p_reg <= {scl_p_reg[0], ~scl_oe_reg};
         busy_p_reg <= {busy_p_reg[0], busy_reg};
         bcg_p1_reg <= bcg_reg;
         bcg_p2_reg <= bcg_p1_reg;
      end
   end
   always_ff @(posedge link_clk or negedge presetn) begin
      if (!presetn) begin
         ce_l_reg <= 2'h0;
         srst_l_reg <= 2'h0;
         sda_lvl_l_reg <= 2'h3;
         mode_l1_reg <= '0;
         mode_l2_reg <= '0;
         start_l_reg <= 3'h0;
         bcld_l_reg <= 3'h0;
         sda_in_reg <= 2'h3;
         scl_in_reg <= 2'h3;
      end else begin
         ce_l_reg <= {ce_l_reg[0], ce};
         srst_l_reg <= {srst_l_reg[0], srst_reg};
         sda_lvl_l_reg <= {sda_lvl_l_reg[0], sda_lvl_reg};
         mode_l1_reg <= mode_reg;
         mode_l2_reg <= mode_l1_reg;
         start_l_reg <= {start_l_reg[1:0], start_tgl_reg};
         bcld_l_reg <= {bcld_l_reg[1:0], bcld_tgl_reg};
         sda_in_reg <= {sda_in_reg[0], sda_i};
         scl_in_reg <= {scl_in_reg[0], scl_i};
      end
   end

   // ----------------------------------------------------------------
   // engine decode
   // ----------------------------------------------------------------
   wire logic ce_l = ce_l_reg[1];
   wire logic srst_l = srst_l_reg[1];
   wire logic start_evt = start_l_reg[2] ^ start_l_reg[1];
   wire logic bcld_evt = bcld_l_reg[2] ^ bcld_l_reg[1];
   wire logic i2c = mode_l2_reg.i2c_fmt;
   wire logic use_wait = mode_l2_reg.wait_en & mode_l2_reg.master & i2c;
   wire logic ack_bit = i2c & (rem_reg == 4'h1);
   wire logic out_bit = mode_l2_reg.lsb_first ? sh_reg[0] : sh_reg[7];
   wire logic in_bit = sda_in_reg[1];
   wire logic [3:0] bc_ext = {1'b0, bc_reg};
   wire logic [3:0] n_bits = (bc_reg == 3'h0) ?
                             (i2c ? `LNCTL_BITS_I2C_FULL : `LNCTL_BITS_SYNC_FULL) :
                             (i2c ? bc_ext + 4'h1 : bc_ext);
   wire logic [7:0] sh_nx = mode_l2_reg.lsb_first ? {1'b0, sh_reg[7:1]} :
                            {sh_reg[6:0], 1'b0};
   wire logic [7:0] rx_nx = mode_l2_reg.lsb_first ? {in_bit, rx_reg[7:1]} :
                            {rx_reg[6:0], in_bit};
   wire logic last_bit = rem_reg == 4'h1;
   wire logic pre_ack = i2c & (rem_reg == 4'h2);
   wire logic [7:0] wait_load = 8'(WAIT_LINK_CYC - 1);

   // ----------------------------------------------------------------
   // bit counter (a register: soft reset leaves it alone)
   // ----------------------------------------------------------------
   always_ff @(posedge link_clk or negedge presetn) begin
      if (!presetn) begin
         bc_reg <= 3'h0;
         bcg_reg <= 3'h0;
      end else if (ce_l) begin
         bcg_reg <= bin2gray(bc_reg);
         if (state_reg == LNCTL_ST_HIGH && !srst_l)
            bc_reg <= last_bit ? 3'h0 : bc_reg - 3'h1;
         else if (bcld_evt)
            bc_reg <= bcld_val_reg;
      end
   end

   // ----------------------------------------------------------------
   // serial engine
   // ----------------------------------------------------------------
   always_ff @(posedge link_clk or negedge presetn) begin
      if (!presetn) begin
         state_reg <= LNCTL_ST_IDLE;
         rem_reg <= 4'h0;
         wcnt_reg <= 8'h00;
         busy_reg <= 1'b0;
      end else if (ce_l) begin
         if (srst_l) begin
            state_reg <= LNCTL_ST_IDLE;
            rem_reg <= 4'h0;
            wcnt_reg <= 8'h00;
            busy_reg <= 1'b0;
         end else begin
            case (state_reg)
               LNCTL_ST_IDLE: begin
                  if (start_evt) begin
                     state_reg <= LNCTL_ST_LOW;
                     rem_reg <= n_bits;
                     busy_reg <= 1'b1;
                  end
               end
               LNCTL_ST_LOW: state_reg <= LNCTL_ST_HIGH;
               LNCTL_ST_HIGH: begin
                  rem_reg <= rem_reg - 4'h1;
                  if (last_bit) begin
                     state_reg <= LNCTL_ST_IDLE;
                     busy_reg <= 1'b0;
                  end else if (pre_ack && use_wait) begin
                     state_reg <= LNCTL_ST_WAIT;
                     wcnt_reg <= wait_load;
                  end else begin
                     state_reg <= LNCTL_ST_LOW;
                  end
               end
               LNCTL_ST_WAIT: begin
                  wcnt_reg <= wcnt_reg - 8'h01;
                  if (wcnt_reg == 8'h00)
                     state_reg <= LNCTL_ST_LOW;
               end
               default: state_reg <= LNCTL_ST_IDLE;
            endcase
         end
      end
   end

   // ----------------------------------------------------------------
   // data path and pins
   // ----------------------------------------------------------------
   always_ff @(posedge link_clk or negedge presetn) begin
      if (!presetn) begin
         sh_reg <= 8'h00;
         rx_reg <= 8'h00;
         done_tgl_reg <= 1'b0;
         scl_oe_reg <= 1'b0;
         sda_oe_reg <= 1'b0;
      end else if (ce_l) begin
         if (srst_l || state_reg == LNCTL_ST_IDLE) begin
            scl_oe_reg <= 1'b0;
            sda_oe_reg <= ~sda_lvl_l_reg[1];
            if (start_evt && !srst_l)
               sh_reg <= tx_reg;
         end else begin
            case (state_reg)
               LNCTL_ST_LOW: begin
                  scl_oe_reg <= 1'b1;
                  sda_oe_reg <= ack_bit ? 1'b0 : ~out_bit;
               end
               LNCTL_ST_HIGH: begin
                  scl_oe_reg <= 1'b0;
                  if (!ack_bit) begin
                     rx_reg <= rx_nx;
                     sh_reg <= sh_nx;
                  end
                  if (last_bit)
                     done_tgl_reg <= ~done_tgl_reg;
               end
               LNCTL_ST_WAIT: scl_oe_reg <= 1'b1;
               default: scl_oe_reg <= 1'b0;
            endcase
         end
      end
   end

   assign prdata = prdata_reg;
   assign pready = pready_reg;
   assign pslverr = pslverr_reg;
   assign scl_oe = scl_oe_reg;
   assign sda_oe = sda_oe_reg;
   assign scl_o = 1'b0;
   assign sda_o = 1'b0;

endmodule : lnctl_top

/* File: sim/lnctl_top_assertions.sv */
/* port checker of lnctl_top.
   assumes the bind below, apb3 master, one link_clk per scl half period. */
`timescale 1ns/1ps
`include "lnctl_defs.svh"
module lnctl_top_assertions #(
   parameter int WAIT_LINK_CYC = 4
) (
   // system
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   // apb
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // link
   input wire logic link_clk,
   input wire logic scl_i,
   input wire logic scl_o,
   input wire logic scl_oe,
   input wire logic sda_i,
   input wire logic sda_o,
   input wire logic sda_oe
);
   wire rd_ans = pready && !pwrite && !pslverr;
   wire line_wr = pready && pwrite && !pslverr && paddr == `LNCTL_OFS_LINE;
   logic srst_reg;
   logic [1:0] srst_cnt_reg;
   logic [7:0] low_run_reg;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         srst_reg <= 1'b0;
         srst_cnt_reg <= 2'h0;
      end else begin
         srst_reg <= line_wr ? pwdata[1] : srst_reg;
         srst_cnt_reg <= !srst_reg ? 2'h0 : (srst_cnt_reg == 2'h3 ? 2'h3 : srst_cnt_reg + 2'h1);
      end
   end
   always_ff @(posedge link_clk or negedge presetn) begin
      if (!presetn) low_run_reg <= 8'h0;
      else low_run_reg <= scl_oe ? low_run_reg + 8'h1 : 8'h0;
   end
   ready_timing_a: assert property (@(posedge pclk) disable iff (!presetn)
      psel && penable && ce && !pready |=> pready) else $error("late apb answer");
   ready_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
      pready |=> !pready) else $error("pready longer than one cycle");
   err_with_ready_a: assert property (@(posedge pclk) disable iff (!presetn)
      pslverr |-> pready && psel && penable) else $error("pslverr outside answer");
   rdata_quiet_a: assert property (@(posedge pclk) disable iff (!presetn)
      !rd_ans |-> prdata == 32'h0) else $error("prdata outside read answer");
   line_resv_a: assert property (@(posedge pclk) disable iff (!presetn)
      rd_ans && paddr == `LNCTL_OFS_LINE |-> prdata[4] && prdata[2] && prdata[0]
      && prdata[31:8] == 24'h0) else $error("line register fixed bits wrong");
   mode_resv_a: assert property (@(posedge pclk) disable iff (!presetn)
      rd_ans && paddr == `LNCTL_OFS_MODE |-> prdata[5:4] == 2'h3 && prdata[3])
      else $error("mode register fixed bits wrong");
   open_drain_a: assert property (@(posedge pclk) disable iff (!presetn)
      1'b1 |-> !scl_o && !sda_o) else $error("pin driven high");
   soft_reset_a: assert property (@(posedge pclk) disable iff (!presetn)
      srst_cnt_reg == 2'h3 |-> !scl_oe) else $error("scl driven in soft reset");
   scl_low_bound_a: assert property (@(posedge link_clk) disable iff (!presetn)
      scl_oe |-> low_run_reg < 8'(WAIT_LINK_CYC + 1)) else $error("scl low too long");
endmodule : lnctl_top_assertions

bind lnctl_top lnctl_top_assertions #(.WAIT_LINK_CYC(WAIT_LINK_CYC)) chk_i (
   .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .link_clk(link_clk), .scl_i(scl_i), .scl_o(scl_o),
   .scl_oe(scl_oe), .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe));

/* File: sim/lnctl_bus_model.sv */
/* serial bus side: pull-ups, an acking device, a recorder of bits and low runs.
   assumes open-drain enables from the block, link_clk as engine clock. */
`timescale 1ns/1ps
module lnctl_bus_model (
   // control
   input wire logic link_clk,
   input wire logic clr,
   input wire logic ack_en,
   // wires
   input wire logic scl_oe,
   input wire logic sda_oe,
   output logic scl,
   output logic sda,
   // record
   output logic [3:0] rises,
   output logic [3:0] max_low,
   output logic [8:0] rx
);
   logic scl_q;
   logic [3:0] low_run;
   wire ack_drv = ack_en && (rises == 4'h8 || (rises == 4'h9 && scl));
   assign scl = !scl_oe;
   assign sda = !(sda_oe || ack_drv);
   always @(posedge link_clk) begin
      scl_q <= scl;
      if (clr) begin
         rises <= 4'h0;
         max_low <= 4'h0;
         low_run <= 4'h0;
         rx <= 9'h0;
      end else begin
         if (!scl_q && scl) begin
            rises <= rises + 4'h1;
            rx <= {rx[7:0], sda};
         end
         low_run <= scl ? 4'h0 : low_run + 4'h1;
         if (!scl && low_run + 4'h1 > max_low) max_low <= low_run + 4'h1;
      end
   end
endmodule : lnctl_bus_model

/* File: sim/lnctl_top_bench.sv */
/* register-level bench of lnctl_top with the bus model.
   assumes the checker bound by its own file. */
`timescale 1ns/1ps
`include "lnctl_defs.svh"
module lnctl_top_bench
   import lnctl_pkg::*;
;
   localparam int WAIT_CYC = 4;
   logic pclk = 0, presetn = 0, ce = 1, psel = 0, penable = 0, pwrite = 0;
   logic link_clk = 0, clr = 0, ack_en = 0, err;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata, rd;
   logic pready, pslverr, scl_o, scl_oe, sda_o, sda_oe, scl, sda;
   logic [3:0] rises, max_low;
   logic [8:0] rx;
   int n_fail = 0, num_checks = 0;
   always #50 pclk = ~pclk;
   always #16 link_clk = ~link_clk;
   lnctl_top #(.WAIT_LINK_CYC(WAIT_CYC)) dut (.pclk(pclk), .presetn(presetn), .ce(ce),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .link_clk(link_clk),
      .scl_i(scl), .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda), .sda_o(sda_o),
      .sda_oe(sda_oe));
   lnctl_bus_model model (.link_clk(link_clk), .clr(clr), .ack_en(ack_en),
      .scl_oe(scl_oe), .sda_oe(sda_oe), .scl(scl), .sda(sda), .rises(rises),
      .max_low(max_low), .rx(rx));
   task summarize;
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : summarize
   task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      n = 0;
      @(posedge pclk);
      while (pready !== 1'b1 && n < 20) begin
         @(posedge pclk);
         n++;
      end
      if (n >= 20) begin
         n_fail++;
         summarize();
      end
      rd = prdata;
      err = pslverr;
      psel <= 0; penable <= 0;
   endtask : xfer
   task rchk(input string what, input logic [11:0] a, input logic [7:0] exp);
      xfer(0, a, 32'h0);
      chk(what, rd, {24'h0, exp});
      chk("pslverr", 32'(err), 32'h0);
   endtask : rchk
   task pin(input string what, input logic exp);
      repeat (4) @(posedge pclk);
      chk(what, 32'(sda), 32'(exp));
   endtask : pin
   task run(input logic [7:0] ctl, input logic [7:0] tx, input logic [3:0] n_exp,
            input logic [3:0] low_exp, input logic [8:0] bits_exp);
      int n;
      xfer(1, `LNCTL_OFS_DATA, {24'h0, tx});
      clr <= 1;
      @(posedge pclk);
      clr <= 0;
      xfer(1, `LNCTL_OFS_XCTL, {24'h0, ctl | 8'h01});
      repeat (4) @(posedge pclk);
      n = 0;
      do begin
         xfer(0, `LNCTL_OFS_XCTL, 32'h0);
         n++;
      end while (rd[7] !== 1'b0 && n < 50);
      if (n >= 50) begin
         n_fail++;
         summarize();
      end
      chk("scl rises", 32'(rises), 32'(n_exp));
      chk("scl low run", 32'(max_low), 32'(low_exp));
      chk("wire bits", 32'(rx), 32'(bits_exp));
   endtask : run
   initial begin
      #200000;
      n_fail++;
      summarize();
   end
   // ----------------------------------------------------------------
   // tests
   // ----------------------------------------------------------------
   initial begin
      repeat (3) @(posedge pclk);
      presetn <= 1;
      repeat (4) @(posedge pclk);
      rchk("line reset", `LNCTL_OFS_LINE, 8'h7d);
      rchk("mode reset", `LNCTL_OFS_MODE, 8'h38);
      xfer(0, 12'h010, 32'h0);
      chk("unmapped err", 32'(err), 32'h1);
      chk("unmapped data", rd, 32'h0);
      $display("test reset done");
      xfer(1, `LNCTL_OFS_LINE, 32'h10);
      rchk("line protected", `LNCTL_OFS_LINE, 8'h7d);
      pin("sda protected", 1'b1);
      xfer(1, `LNCTL_OFS_LINE, 32'h00);
      rchk("line sda low", `LNCTL_OFS_LINE, 8'h5d);
      pin("sda low", 1'b0);
      xfer(1, `LNCTL_OFS_LINE, 32'h20);
      rchk("line sda high", `LNCTL_OFS_LINE, 8'h7d);
      pin("sda released", 1'b1);
      $display("test sda level done");
      xfer(1, `LNCTL_OFS_XCTL, 32'h06);
      xfer(1, `LNCTL_OFS_MODE, 32'h0b);
      rchk("counter protected", `LNCTL_OFS_MODE, 8'h38);
      xfer(1, `LNCTL_OFS_MODE, 32'h03);
      repeat (4) @(posedge pclk);
      rchk("counter loaded", `LNCTL_OFS_MODE, 8'h3b);
      $display("test counter protect done");
      run(8'h06, 8'ha5, 4'h4, 4'h1, 9'h00b);
      repeat (4) @(posedge pclk);
      rchk("counter cleared", `LNCTL_OFS_MODE, 8'h38);
      ack_en <= 1;
      xfer(1, `LNCTL_OFS_MODE, 32'h40);
      run(8'h06, 8'h3c, 4'h9, 4'(1 + WAIT_CYC), {8'h3c, 1'b0});
      run(8'h04, 8'h3c, 4'h9, 4'h1, {8'h3c, 1'b0});
      $display("test i2c transfers done");
      ack_en <= 0;
      xfer(1, `LNCTL_OFS_MODE, 32'hc8);
      run(8'h02, 8'h01, 4'h8, 4'h1, 9'h080);
      $display("test sync transfer done");
      xfer(1, `LNCTL_OFS_LINE, 32'h12);
      rchk("line soft reset", `LNCTL_OFS_LINE, 8'h7f);
      rchk("mode kept", `LNCTL_OFS_MODE, 8'hf8);
      clr <= 1;
      @(posedge pclk);
      clr <= 0;
      xfer(1, `LNCTL_OFS_XCTL, 32'h03);
      repeat (20) @(posedge pclk);
      chk("held engine rises", 32'(rises), 32'h0);
      xfer(1, `LNCTL_OFS_LINE, 32'h30);
      repeat (20) @(posedge pclk);
      run(8'h02, 8'h01, 4'h8, 4'h1, 9'h080);
      rchk("line after soft reset", `LNCTL_OFS_LINE, 8'h7d);
      $display("test soft reset done");
      summarize();
   end
endmodule : lnctl_top_bench
